/* File: bench/adc_link_checker.sv */
// Protocol checker for the converter serial link
`timescale 1ns/100ps
module adc_link_checker (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic result_ready_n
);
  logic       sclk_q;
  logic       fall;
  logic       rise;
  logic [5:0] cnt;
  logic [7:0] op;
  logic [7:0] op_now;
  assign fall = sclk_q & ~sclk;
  assign rise = ~sclk_q & sclk;
  assign op_now = {op[6:0], din};
  // Bit count and opcode of the frame; deselect clears both
  always_ff @(posedge i_clk) begin
    sclk_q <= sclk;
    if (!i_resetn || cs_n) begin
      cnt <= 6'h00;
      op <= 8'h00;
    end else if (fall) begin
      cnt <= cnt + 6'h01;
      if (cnt < 6'h08) op <= op_now;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  a_idle_release: assert property (cs_n [*6] |-> !dout_oe)
    else $error("data out driven while deselected");
  a_sclk_parked: assert property (cs_n |-> !sclk)
    else $error("serial clock not low while idle");
  a_sclk_high_len: assert property ($rose(sclk) |-> sclk[*8] ##1 !sclk)
    else $error("serial clock high phase wrong");
  a_din_at_fall: assert property ($fell(sclk) |-> $stable(din))
    else $error("data in moved at capture edge");
  a_dout_launch: assert property (
    dout_oe && $past(dout_oe) && $changed(dout) |-> sclk)
    else $error("data out changed outside high phase");
  a_frame_whole: assert property (
    $rose(cs_n) |-> cnt == 6'h08 || cnt == 6'h20)
    else $error("frame cut short");
  a_cal_ready_high: assert property (
    fall && cnt == 6'h07 && op_now >= 8'hF0 && op_now <= 8'hF4
    |-> ##[1:12] result_ready_n [*8])
    else $error("ready not held high at calibration");
  a_read_clears: assert property (
    rise && cnt == 6'h1F && op == 8'h01 |-> ##[0:14] result_ready_n)
    else $error("ready not raised after result read");
  a_write_sync: assert property (
    rise && cnt == 6'h1F && (op == 8'h50 || op == 8'h51)
    |-> ##[0:14] result_ready_n)
    else $error("ready not raised after correction write");
  a_reset_cal: assert property ($rose(i_resetn) |-> result_ready_n [*8])
    else $error("ready low right after reset");
endmodule

/* File: bench/tb_adc_calibration_output_port.sv */
// Testbench: AHB-Lite software drives the controller, linked to the converter
`timescale 1ns/100ps
`include "adc_link_defines.svh"
module tb_adc_calibration_output_port;
  localparam logic [23:0] MID = 24'hFF_FFF0;
  localparam logic [23:0] REFV = 24'h5F_FFF0;
  localparam logic [23:0] SZERO = 24'h00_0020;
  localparam logic [23:0] SFULL = 24'h70_0000;
  localparam logic [23:0] TBL [6] = '{24'h00_0040, 24'h00_0041, 24'h00_003F,
    24'h00_0100, 24'h7F_FFFF, 24'h80_0000};
  localparam logic [7:0] CAL [5] = '{`OPC_SELF_OFS, `OPC_SELF_GAIN,
    `OPC_SELF_FULL, `OPC_SYS_OFS, `OPC_SYS_GAIN};
  logic        i_clk = 1'b0;
  logic        i_resetn, hsel, hwrite, hready, rate_slow, svalid, clk_out;
  logic [1:0]  htrans, stim, input_sel;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [23:0] sample, sig;
  logic [3:0]  scnt;
  int          cyc, failures, n_compared;
  adc_link_if lnk ();
  adc_cal_host adc_cal_host_inst (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(), .o_rate_slow(rate_slow),
    .o_stim_sel(stim), .lnk(lnk));
  // Master clock 64 times the reference shrinks the fast counts
  adc_cal_device #(.MCLK_HZ(32'h1D4C_0000), .OFS_SLOW_CYC(200),
    .GAIN_SLOW_CYC(210), .FULL_SLOW_CYC(330))
    adc_cal_device_inst (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_sample(sample), .i_sample_valid(svalid), .i_slow_rate(rate_slow),
    .o_input_sel(input_sel), .o_clock_output_pin(clk_out), .lnk(lnk));
  adc_link_checker adc_link_checker_inst (.i_clk(i_clk), .i_resetn(i_resetn),
    .cs_n(lnk.cs_n), .sclk(lnk.sclk), .din(lnk.din), .dout(lnk.dout),
    .dout_oe(lnk.dout_oe), .result_ready_n(lnk.result_ready_n));
  always #50 i_clk = ~i_clk;
  // Front end: one sample every 16 cycles, picked by mux and stimulus
  always @(posedge i_clk) begin
    scnt <= scnt + 4'h1;
    svalid <= (scnt == 4'hF);
    if (input_sel == `SEL_MID) sample <= MID;
    else if (input_sel == `SEL_REF) sample <= REFV;
    else if (stim == `STIM_ZERO) sample <= SZERO;
    else if (stim == `STIM_FULL) sample <= SFULL;
    else sample <= sig;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [23:0] s, e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  // One single word transfer; request held until hready is seen high
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge i_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask
  task automatic idle(input int bit_n);
    logic [31:0] q;
    do ahb(1'b0, `OFF_STATUS, 32'h0, q); while (q[bit_n] !== 1'b0);
  endtask
  task automatic cmd(input logic [7:0] op);
    wr(`OFF_CMD, {24'h00_0000, op});
    idle(0);
  endtask
  task automatic rd_word(input logic [7:0] op, output logic [23:0] v);
    logic [31:0] q;
    cmd(op);
    ahb(1'b0, `OFF_RDATA, 32'h0, q);
    v = q[23:0];
  endtask
  task automatic wr_word(input logic [7:0] op, input logic [23:0] d);
    wr(`OFF_WDATA, {8'h00, d});
    cmd(op);
  endtask
  // Cycles that ready stays high over a self offset calibration
  task automatic cal_time(input int lo, input int hi);
    int n;
    n = 0;
    wr(`OFF_CMD, {24'h00_0000, `OPC_SELF_OFS});
    while (lnk.result_ready_n !== 1'b1) @(posedge i_clk);
    while (lnk.result_ready_n !== 1'b0) begin
      @(posedge i_clk);
      n++;
    end
    check("cal_time", 24'(n >= lo && n <= hi), 24'h00_0001);
    idle(0);
  endtask
  function automatic logic [23:0] model(logic [23:0] x, o, g);
    longint v;
    v = ((longint'($signed(x)) - longint'($signed(o))) * longint'(g)) >>> 22;
    if (v > longint'(24'h7F_FFFF)) return 24'h7F_FFFF;
    if (v < -longint'(24'h80_0000)) return 24'h80_0000;
    return v[23:0];
  endfunction
  function automatic logic [23:0] gcal(logic [23:0] s, o);
    longint q;
    q = (longint'(24'h7F_FFFF) <<< 22) /
        (longint'($signed(s)) - longint'($signed(o)));
    return (q > longint'(24'hFF_FFFF)) ? 24'hFF_FFFF : q[23:0];
  endfunction
  initial begin
    logic [31:0] q;
    logic [23:0] v, eo, eg;
    int n;
    logic prev;
    {i_resetn, hsel, hwrite, svalid, prev} = '0;
    {htrans, hsize, haddr, hwdata, sample, sig, scnt} = '0;
    {cyc, failures, n_compared, n} = '0;
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'b1;
    idle(1);
    eo = MID;
    eg = gcal(REFV, MID);
    // Result path: self-calibrated, then with written corrections
    for (int p = 0; p < 2; p++) begin
      if (p == 1) begin
        eo = 24'h00_0040;
        eg = 24'h40_0000;
        wr_word(`OPC_WR_OFS, eo);
        wr_word(`OPC_WR_GAIN, eg);
      end
      rd_word(`OPC_RD_OFS, v);
      check("offset", v, eo);
      rd_word(`OPC_RD_GAIN, v);
      check("gain", v, eg);
      foreach (TBL[i]) begin
        sig <= TBL[i];
        repeat (40) @(posedge i_clk);
        rd_word(`OPC_READ_RESULT, v);
        check("result", v, model(TBL[i], eo, eg));
      end
    end
    // Each calibration command from a known starting state
    foreach (CAL[k]) begin
      wr_word(`OPC_WR_OFS, 24'h00_0123);
      wr_word(`OPC_WR_GAIN, 24'h40_0000);
      idle(1); // Ready low first so the stimulus spans this calibration
      cmd(CAL[k]);
      idle(1);
      eo = (k == 0 || k == 2) ? MID : (k == 3) ? SZERO : 24'h00_0123;
      eg = (k == 1 || k == 2) ? gcal(REFV, eo) :
           (k == 4) ? gcal(SFULL, eo) : 24'h40_0000;
      rd_word(`OPC_RD_OFS, v);
      check("cal_offset", v, eo);
      rd_word(`OPC_RD_GAIN, v);
      check("cal_gain", v, eg);
    end
    cal_time(60, 140);
    // Rate change must bring its own full calibration
    wr(`OFF_CTRL, 32'h0000_0001);
    while (lnk.cs_n !== 1'b0) @(posedge i_clk);
    idle(0);
    idle(1);
    rd_word(`OPC_RD_OFS, v);
    check("rate_recal", v, MID);
    cal_time(200, 280);
    ahb(1'b0, 8'h14, 32'h0, q);
    check("unmapped", q[23:0], 24'h00_0000);
    // Clock output: one period every four system clocks
    @(negedge i_clk);
    prev = clk_out;
    repeat (400) begin
      @(negedge i_clk);
      if (clk_out && !prev) n++;
      prev = clk_out;
    end
    check("clock_out", 24'(n), 24'h00_0064);
    stop_test();
  end
endmodule

/* File: common/adc_link_defines.svh */
// Shared constants for the converter serial link and its host controller
`ifndef ADC_LINK_DEFINES_SVH
`define ADC_LINK_DEFINES_SVH
// Timing base: system clock period and reference master clock
`define CLK_PERIOD_NS   100
`define REF_MCLK_HZ     7680000
// Calibration times in ns, fastest and slowest data rate
`define OFS_FAST_NS     453000
`define OFS_SLOW_NS     800300000
`define GAIN_FAST_NS    484000
`define GAIN_SLOW_NS    800300000
`define FULL_FAST_NS    696000
`define FULL_SLOW_NS    1227200000
// Output code limits and correction reset values
`define CODE_MAX        24'h7F_FFFF
`define CODE_MIN        24'h80_0000
`define GAIN_MAX        24'hFF_FFFF
`define OFC_RESET       24'h00_0000
`define FSC_RESET       24'h40_0000
`define GAIN_SHIFT      22
`define DIV_STEPS       6'h2E
// Command opcodes
`define OPC_READ_RESULT 8'h01
`define OPC_RD_OFS      8'h10
`define OPC_RD_GAIN     8'h11
`define OPC_WR_OFS      8'h50
`define OPC_WR_GAIN     8'h51
`define OPC_SELF_OFS    8'hF0
`define OPC_SELF_GAIN   8'hF1
`define OPC_SELF_FULL   8'hF2
`define OPC_SYS_OFS     8'hF3
`define OPC_SYS_GAIN    8'hF4
// Frame lengths in serial clocks
`define CMD_BITS        6'h08
`define WORD_BITS       6'h18
`define FRAME_BITS      6'h20
// Analogue input selection
`define SEL_SIGNAL      2'h0
`define SEL_MID         2'h1
`define SEL_REF         2'h2
// Host stimulus request
`define STIM_NONE       2'h0
`define STIM_ZERO       2'h1
`define STIM_FULL       2'h2
// Host register byte offsets
`define OFF_CMD         8'h00
`define OFF_WDATA       8'h04
`define OFF_RDATA       8'h08
`define OFF_STATUS      8'h0C
`define OFF_CTRL        8'h10
// Host serial clock half period and device clock output divider
`define HOST_HALF       8
`define CLKOUT_DIV      2
`endif

/* File: common/adc_link_if.sv */
// Serial link between converter and controller, one modport per end
`timescale 1ns/100ps
interface adc_link_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe;
  logic dout_line;
  logic result_ready_n;
  // Released data line reads high, as with a weak pull-up
  assign dout_line = dout_oe ? dout : 1'b1;
  modport device (input cs_n, input sclk, input din,
                  output dout, output dout_oe, output result_ready_n);
  modport host (output cs_n, output sclk, output din,
                input dout_line, input result_ready_n);
endinterface

/* File: common/adc_pkg.sv */
// Types and helpers shared by both ends of the converter link
`include "adc_link_defines.svh"
package adc_pkg;
  typedef enum logic [1:0] {
    SER_CMD = 2'b00,
    SER_IN  = 2'b01,
    SER_OUT = 2'b10
  } ser_e;
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_OFS  = 2'b01,
    CAL_GAIN = 2'b10,
    CAL_DIV  = 2'b11
  } cal_e;
  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_SETUP = 2'b01,
    H_HIGH  = 2'b10,
    H_LOW   = 2'b11
  } host_e;
  // Cycles of the system clock for a time given at the reference clock
  function automatic int unsigned cal_cycles(int unsigned ns,
                                             int unsigned mclk);
    longint unsigned c;
    c = (64'(ns) * 64'(`REF_MCLK_HZ)) / (64'(mclk) * 64'(`CLK_PERIOD_NS));
    if (c == 64'h0) c = 64'h1;
    return int'(c);
  endfunction
endpackage

/* File: logic/adc_cal_device.sv */
// Converter end: result path, correction, calibration and serial port
// Functional notes
// - Results are 24-bit signed binary words.
// - Zero codes zero; overrange clamps to extremes.
// - Offset and gain corrections are 24-bit RW.
// - Output is (input minus offset) times gain.
// - Five calibration commands, any amplifier gain.
// - Ready held high through calibration.
// - Self-calibration runs automatically after reset.
// - Host recalibrates after every data rate change.
// - Self offset: inputs at mid-supply, store offset.
// - Calibration times scale inversely with master clock.
// - Self gain: inputs on references, store gain.
// - Full self: offset then gain, both stored.
// - System offset needs zero input from host.
// - System gain needs near full-scale input.
// - Host keeps chip select low whole transaction.
// - Chip select high resets port, releases output.
// - Chip select may stay low permanently.
// - Ready goes low when a result exists.
// - Host parks serial clock low when idle.
// - Dedicated clock output pin for other devices.
// - Capture on falling edge, launch on rising.
// - Ready returns high after 24 result bits.
// - Correction write forces ready high until data.
//
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
`include "adc_link_defines.svh"
module adc_cal_device #(
  parameter int unsigned MCLK_HZ = `REF_MCLK_HZ,
  parameter int unsigned OFS_FAST_CYC =
    adc_pkg::cal_cycles(`OFS_FAST_NS, MCLK_HZ),
  parameter int unsigned OFS_SLOW_CYC =
    adc_pkg::cal_cycles(`OFS_SLOW_NS, MCLK_HZ),
  parameter int unsigned GAIN_FAST_CYC =
    adc_pkg::cal_cycles(`GAIN_FAST_NS, MCLK_HZ),
  parameter int unsigned GAIN_SLOW_CYC =
    adc_pkg::cal_cycles(`GAIN_SLOW_NS, MCLK_HZ),
  parameter int unsigned FULL_FAST_CYC =
    adc_pkg::cal_cycles(`FULL_FAST_NS, MCLK_HZ),
  parameter int unsigned FULL_SLOW_CYC =
    adc_pkg::cal_cycles(`FULL_SLOW_NS, MCLK_HZ),
  parameter int unsigned CLKOUT_DIV = `CLKOUT_DIV
) (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic [23:0] i_sample,
  input  wire logic        i_sample_valid,
  input  wire logic        i_slow_rate,
  output logic      [1:0]  o_input_sel,
  output logic             o_clock_output_pin,
  adc_link_if.device       lnk
);
  typedef struct packed {
    logic [2:0]     sclk_sy;
    logic           sclk_q;
    logic [2:0]     cs_sy;
    logic           cs_q;
    logic [2:0]     din_sy;
    logic           din_q;
    adc_pkg::ser_e  ser;
    logic [5:0]     bits;
    logic [7:0]     cmd;
    logic [23:0]    sh;
    logic           sdo;
    logic           sdo_oe;
    logic           rdy_n;
    logic [23:0]    result;
    logic [23:0]    offset_correction;
    logic [23:0]    gain_correction;
    logic [23:0]    smp;
    adc_pkg::cal_e  cal;
    logic           full;
    logic [23:0]    cnt;
    logic [23:0]    dvs;
    logic [45:0]    num;
    logic [24:0]    rem;
    logic [5:0]     dcnt;
    logic [1:0]     sel;
    logic [7:0]     ckdiv;
    logic           ckout;
  } dev_s;

  dev_s r;
  dev_s n;

  // Next state of the whole converter end
  always_comb begin
    logic        rise;
    logic        fall;
    logic [7:0]  opc;
    logic [23:0] ofs_cyc;
    logic [23:0] gain_cyc;
    logic [23:0] fofs_cyc;
    logic [24:0] diff;
    logic [49:0] prod;
    logic [49:0] scl;
    logic [23:0] code;
    logic [24:0] rsh;
    logic        ge;
    logic [45:0] qn;
    logic [24:0] gd;
    rise = 1'b0;
    fall = 1'b0;
    opc  = 8'h00;
    n = r;
    // Selected rate picks the calibration durations
    ofs_cyc  = i_slow_rate ? 24'(OFS_SLOW_CYC) : 24'(OFS_FAST_CYC);
    gain_cyc = i_slow_rate ? 24'(GAIN_SLOW_CYC) : 24'(GAIN_FAST_CYC);
    fofs_cyc = i_slow_rate ? 24'(FULL_SLOW_CYC - GAIN_SLOW_CYC)
                           : 24'(FULL_FAST_CYC - GAIN_FAST_CYC);
    // Correction: subtract offset, scale by gain, clamp
    diff = $signed({i_sample[23], i_sample}) -
           $signed({r.offset_correction[23], r.offset_correction});
    prod = 50'($signed(diff) * $signed({1'b0, r.gain_correction}));
    scl  = 50'($signed(prod) >>> `GAIN_SHIFT);
    if (scl[49:23] != {27{scl[49]}}) begin
      code = scl[49] ? `CODE_MIN : `CODE_MAX;
    end else begin
      code = scl[23:0];
    end
    // Divider step for the gain coefficient
    rsh = {r.rem[23:0], r.num[45]};
    ge  = (rsh >= {1'b0, r.dvs});
    qn  = {r.num[44:0], ge};
    gd  = $signed({r.smp[23], r.smp}) - $signed({r.offset_correction[23], r.offset_correction});

    // Pin synchronisers: a level counts once stages two and three agree
    n.sclk_sy = {r.sclk_sy[1:0], lnk.sclk};
    n.cs_sy   = {r.cs_sy[1:0], lnk.cs_n};
    n.din_sy  = {r.din_sy[1:0], lnk.din};
    if (r.sclk_sy[1] == r.sclk_sy[2]) begin
      n.sclk_q = r.sclk_sy[2];
      rise = r.sclk_sy[2] && !r.sclk_q;
      fall = !r.sclk_sy[2] && r.sclk_q;
    end
    if (r.cs_sy[1] == r.cs_sy[2]) n.cs_q = r.cs_sy[2];
    if (r.din_sy[1] == r.din_sy[2]) n.din_q = r.din_sy[2];

    // Clock output for other devices, free running
    if (r.ckdiv == 8'(CLKOUT_DIV - 1)) begin
      n.ckdiv = 8'h00;
      n.ckout = !r.ckout;
    end else begin
      n.ckdiv = r.ckdiv + 8'h01;
    end

    // Calibration engine and conversion path
    if (i_sample_valid) n.smp = i_sample;
    case (r.cal)
      adc_pkg::CAL_IDLE: if (i_sample_valid) begin
        n.result = code;
        n.rdy_n  = 1'b0;
      end
      adc_pkg::CAL_OFS: begin
        n.cnt = r.cnt - 24'h00_0001;
        if (r.cnt <= 24'h00_0001) begin
          n.offset_correction = r.smp;
          if (r.full) begin
            n.cal = adc_pkg::CAL_GAIN;
            n.sel = `SEL_REF;
            n.cnt = gain_cyc;
          end else begin
            n.cal = adc_pkg::CAL_IDLE;
            n.sel = `SEL_SIGNAL;
          end
        end
      end
      adc_pkg::CAL_GAIN: begin
        n.cnt = r.cnt - 24'h00_0001;
        if (r.cnt <= 24'h00_0001) begin
          // Non-positive span gives zero divisor, hence gain saturates
          n.dvs  = gd[24] ? 24'h00_0000 : gd[23:0];
          n.num  = {`CODE_MAX, 22'h00_0000};
          n.rem  = 25'h000_0000;
          n.dcnt = `DIV_STEPS;
          n.cal  = adc_pkg::CAL_DIV;
        end
      end
      adc_pkg::CAL_DIV: begin
        n.rem  = ge ? rsh - {1'b0, r.dvs} : rsh;
        n.num  = qn;
        n.dcnt = r.dcnt - 6'h01;
        if (r.dcnt == 6'h01) begin
          n.gain_correction = (qn[45:24] != 22'h00_0000) ? `GAIN_MAX : qn[23:0];
          n.cal = adc_pkg::CAL_IDLE;
          n.sel = `SEL_SIGNAL;
        end
      end
      default: n.cal = adc_pkg::CAL_IDLE;
    endcase

    // Serial port: framed by bit count, so select may stay low
    if (r.cs_q) begin
      n.ser    = adc_pkg::SER_CMD;
      n.bits   = 6'h00;
      n.sdo    = 1'b0;
      n.sdo_oe = 1'b0;
    end else begin
      n.sdo_oe = 1'b1;
      if (rise && r.ser == adc_pkg::SER_OUT) begin
        n.sdo = r.sh[23];
        n.sh  = {r.sh[22:0], 1'b0};
      end
      if (fall) begin
        n.bits = r.bits + 6'h01;
        case (r.ser)
          adc_pkg::SER_CMD: begin
            opc   = {r.cmd[6:0], r.din_q};
            n.cmd = opc;
            if (r.bits == `CMD_BITS - 6'h01) begin
              n.bits = 6'h00;
              case (opc)
                `OPC_READ_RESULT: begin
                  n.ser = adc_pkg::SER_OUT;
                  n.sh  = r.result;
                end
                `OPC_RD_OFS: begin
                  n.ser = adc_pkg::SER_OUT;
                  n.sh  = r.offset_correction;
                end
                `OPC_RD_GAIN: begin
                  n.ser = adc_pkg::SER_OUT;
                  n.sh  = r.gain_correction;
                end
                `OPC_WR_OFS, `OPC_WR_GAIN: n.ser = adc_pkg::SER_IN;
                default: ;
              endcase
              // Calibration start; a second one arriving while another runs is ignored
              if (r.cal == adc_pkg::CAL_IDLE) begin
                case (opc)
                  `OPC_SELF_OFS, `OPC_SYS_OFS, `OPC_SELF_FULL: begin
                    n.cal   = adc_pkg::CAL_OFS;
                    n.rdy_n = 1'b1;
                    n.full  = (opc == `OPC_SELF_FULL);
                    n.sel   = (opc == `OPC_SYS_OFS) ? `SEL_SIGNAL
                                                    : `SEL_MID;
                    n.cnt   = (opc == `OPC_SELF_FULL) ? fofs_cyc
                                                      : ofs_cyc;
                  end
                  `OPC_SELF_GAIN, `OPC_SYS_GAIN: begin
                    n.cal   = adc_pkg::CAL_GAIN;
                    n.rdy_n = 1'b1;
                    n.full  = 1'b0;
                    n.sel   = (opc == `OPC_SYS_GAIN) ? `SEL_SIGNAL
                                                     : `SEL_REF;
                    n.cnt   = gain_cyc;
                  end
                  default: ;
                endcase
              end
            end
          end
          adc_pkg::SER_IN: begin
            n.sh = {r.sh[22:0], r.din_q};
            if (r.bits == `WORD_BITS - 6'h01) begin
              n.bits  = 6'h00;
              n.ser   = adc_pkg::SER_CMD;
              n.rdy_n = 1'b1;
              if (r.cmd == `OPC_WR_OFS) begin
                n.offset_correction = {r.sh[22:0], r.din_q};
              end else begin
                n.gain_correction = {r.sh[22:0], r.din_q};
              end
            end
          end
          adc_pkg::SER_OUT: begin
            if (r.bits == `WORD_BITS - 6'h01) begin
              n.bits = 6'h00;
              n.ser  = adc_pkg::SER_CMD;
              if (r.cmd == `OPC_READ_RESULT) n.rdy_n = 1'b1;
            end
          end
          default: n.ser = adc_pkg::SER_CMD;
        endcase
      end
    end
  end

  // State register; reset starts a full self-calibration at once
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      r        <= '0;
      r.cs_sy  <= 3'h7;
      r.cs_q   <= 1'b1;
      r.ser    <= adc_pkg::SER_CMD;
      r.rdy_n  <= 1'b1;
      r.offset_correction    <= `OFC_RESET;
      r.gain_correction    <= `FSC_RESET;
      r.cal    <= adc_pkg::CAL_OFS;
      r.full   <= 1'b1;
      r.sel    <= `SEL_MID;
      r.cnt    <= 24'(FULL_FAST_CYC - GAIN_FAST_CYC);
    end else begin
      r <= n;
    end
  end

  assign lnk.dout           = r.sdo;
  assign lnk.dout_oe        = r.sdo_oe;
  assign lnk.result_ready_n = r.rdy_n;
  assign o_input_sel        = r.sel;
  assign o_clock_output_pin = r.ckout;
endmodule

/* File: logic/adc_cal_host.sv */
// Controller end: AHB-Lite register slave driving the serial link
`timescale 1ns/100ps
`include "adc_link_defines.svh"
module adc_cal_host #(
  parameter int unsigned HALF = `HOST_HALF
) (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic             o_rate_slow,
  output logic      [1:0]  o_stim_sel,
  adc_link_if.host         lnk
);
  typedef struct packed {
    logic          a_wr;
    logic [7:0]    a_off;
    logic [31:0]   hrdata;
    logic [23:0]   wdata;
    logic [23:0]   rdata;
    logic [7:0]    op;
    logic          rate_slow;
    logic          cal_pend;
    adc_pkg::host_e st;
    logic [7:0]    div;
    logic [5:0]    bits;
    logic [5:0]    nbits;
    logic [31:0]   so;
    logic [23:0]   si;
    logic          sclk;
    logic          cs_n;
    logic          din;
    logic [2:0]    do_sy;
    logic          do_q;
    logic [2:0]    rd_sy;
    logic          rdy_q;
    logic [1:0]    stim;
    logic          seen_hi;
  } host_s;

  host_s r;
  host_s n;

  // Next state: bus slave, frame sequencer, pin synchronisers
  always_comb begin
    logic       go;
    logic [7:0] gop;
    logic       tick;
    logic       is_rd;
    go    = 1'b0;
    gop   = `OPC_SELF_FULL;
    tick  = (r.div == 8'(HALF - 1));
    is_rd = 1'b0;
    n = r;
    n.do_sy = {r.do_sy[1:0], lnk.dout_line};
    if (r.do_sy[1] == r.do_sy[2]) n.do_q = r.do_sy[2];
    n.rd_sy = {r.rd_sy[1:0], lnk.result_ready_n};
    if (r.rd_sy[1] == r.rd_sy[2]) n.rdy_q = r.rd_sy[2];
    // Address phase: latch write target, prepare read data
    n.a_wr = i_hsel && i_htrans[1] && i_hready && i_hwrite;
    if (i_hsel && i_htrans[1] && i_hready) begin
      n.a_off = i_haddr[7:0];
      case (i_haddr[7:0])
        `OFF_CMD:    n.hrdata = {24'h00_0000, r.op};
        `OFF_WDATA:  n.hrdata = {8'h00, r.wdata};
        `OFF_RDATA:  n.hrdata = {8'h00, r.rdata};
        `OFF_STATUS: n.hrdata = {28'h000_0000, r.stim, r.rdy_q,
                                 r.st != adc_pkg::H_IDLE};
        `OFF_CTRL:   n.hrdata = {31'h0, r.rate_slow};
        default:     n.hrdata = 32'h0000_0000;
      endcase
    end
    // Data phase writes; a command is ignored while a frame runs
    if (r.a_wr) begin
      case (r.a_off)
        `OFF_CMD: begin
          go  = (r.st == adc_pkg::H_IDLE);
          gop = i_hwdata[7:0];
        end
        `OFF_WDATA: n.wdata = i_hwdata[23:0];
        `OFF_CTRL: begin
          n.rate_slow = i_hwdata[0];
          if (i_hwdata[0] != r.rate_slow) n.cal_pend = 1'b1;
        end
        default: ;
      endcase
    end
    // Stimulus request ends once ready has gone high then low again;
    // it comes first so a request issued in the same cycle wins
    if (r.stim != `STIM_NONE) begin
      if (r.rdy_q) n.seen_hi = 1'b1;
      if (r.seen_hi && !r.rdy_q) n.stim = `STIM_NONE;
    end
    // A pending recalibration goes out once the link is free
    if (!go && r.cal_pend && r.st == adc_pkg::H_IDLE) begin
      go = 1'b1;
      n.cal_pend = 1'b0;
    end
    if (go) begin
      n.op  = gop;
      n.so  = {gop, r.wdata};
      n.nbits = (gop == `OPC_READ_RESULT || gop == `OPC_RD_OFS ||
                 gop == `OPC_RD_GAIN || gop == `OPC_WR_OFS ||
                 gop == `OPC_WR_GAIN) ? `FRAME_BITS : `CMD_BITS;
      n.bits = 6'h00;
      n.div  = 8'h00;
      n.cs_n = 1'b0;
      n.st   = adc_pkg::H_SETUP;
      if (gop == `OPC_SYS_OFS) n.stim = `STIM_ZERO;
      if (gop == `OPC_SYS_GAIN) n.stim = `STIM_FULL;
      n.seen_hi = 1'b0;
    end
    is_rd = (r.op == `OPC_READ_RESULT || r.op == `OPC_RD_OFS ||
             r.op == `OPC_RD_GAIN);
    // Serial sequencer: data out on rising, dout sampled at the end of the low half
    if (r.st != adc_pkg::H_IDLE) n.div = tick ? 8'h00 : r.div + 8'h01;
    case (r.st)
      adc_pkg::H_IDLE: n.sclk = 1'b0;
      adc_pkg::H_SETUP, adc_pkg::H_LOW: if (tick) begin
        if (r.st == adc_pkg::H_LOW) begin
          n.si = {r.si[22:0], r.do_q};
          n.bits = r.bits + 6'h01;
        end
        if (r.st == adc_pkg::H_LOW && r.bits + 6'h01 == r.nbits) begin
          n.cs_n = 1'b1;
          n.st   = adc_pkg::H_IDLE;
          if (is_rd) n.rdata = {r.si[22:0], r.do_q};
        end else begin
          n.sclk = 1'b1;
          n.din  = r.so[31];
          n.so   = {r.so[30:0], 1'b0};
          n.st   = adc_pkg::H_HIGH;
        end
      end
      adc_pkg::H_HIGH: if (tick) begin
        n.sclk = 1'b0;
        n.st   = adc_pkg::H_LOW;
      end
      default: n.st = adc_pkg::H_IDLE;
    endcase
  end

  // State register with synchronous reset
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      r         <= '0;
      r.cs_n    <= 1'b1;
      r.do_sy   <= 3'h7;
      r.do_q    <= 1'b1;
      r.rd_sy   <= 3'h7;
      r.rdy_q   <= 1'b1;
      r.st      <= adc_pkg::H_IDLE;
    end else begin
      r <= n;
    end
  end

  assign o_hrdata    = r.hrdata;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign o_rate_slow = r.rate_slow;
  assign o_stim_sel  = r.stim;
  assign lnk.cs_n    = r.cs_n;
  assign lnk.sclk    = r.sclk;
  assign lnk.din     = r.din;
endmodule
